//--- branch_defines.svh
// Constants for the flag conditional branch unit
`ifndef BRANCH_DEFINES_SVH
`define BRANCH_DEFINES_SVH
`define OPC_HI_NO_OVF   8'hE5
`define OPC_HI_NONZERO  8'hE1
`define PC_W            21
`define PC_RESET        21'h000000
`define PC_STEP         21'h000002
`define FLAG_OVF_BIT    3
`define FLAG_ZERO_BIT   2
`define Q_LAST          2'h3
`define Q_FIRST         2'h0
`define Q_DATA          2'h2
`define Q_STEP          2'h1
`define OPCODE_RESET    16'h0000
`define STATUS_RESET    5'h00
`endif

//--- branch_pkg.sv
// Types for the flag conditional branch unit
package branch_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} exec_state_t;
  typedef logic [20:0] pc_t;
endpackage

//--- branch_target.sv
// Branch target adder: incremented PC plus doubled signed offset
`timescale 1ns/10ps
`default_nettype none
`include "branch_defines.svh"
module branch_target
(
  // Operands
  input  wire logic [20:0] pc_inc,
  input  wire logic [7:0]  offset,
  // Result
  output logic      [20:0] target
);
  logic [20:0] off_x2;
  // Sign extend then double
  assign off_x2 = {{12{offset[7]}}, offset, 1'b0};
  assign target = pc_inc + off_x2;
endmodule // branch_target
`default_nettype wire

//--- flag_branch_asserts.sv
// Port timing and flag checks
`timescale 1ns/10ps
`default_nettype none
module flag_branch_asserts
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Instruction in
  input wire logic        instr_valid,
  input wire logic [15:0] opcode,
  input wire logic [4:0]  status_in,
  // Results
  input wire logic        busy,
  input wire logic        pc_load,
  input wire logic        flush,
  input wire logic        done,
  input wire logic        taken,
  input wire logic [4:0]  status_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Word taken by the idle unit
  sequence s_acc;
    instr_valid && !busy;
  endsequence
  // Whole discard cycle, then the end pulse with flush gone
  sequence s_flush_run;
    flush[*4] ##1 (done && !flush);
  endsequence
  a_load_time: assert property (s_acc |-> ##5 pc_load) else $error("late load");
  a_ovf_test: assert property (s_acc ##0 opcode[15:8] == 8'hE5
    |-> ##5 taken == !$past(status_in[3], 5)) else $error("ovf test");
  a_zero_test: assert property (s_acc ##0 opcode[15:8] == 8'hE1
    |-> ##5 taken == !$past(status_in[2], 5)) else $error("zero test");
  a_flush_span: assert property (pc_load && taken |-> s_flush_run) else $error("flush");
  a_flags_kept: assert property (s_acc |-> ##5 status_out == $past(status_in, 5))
    else $error("flags changed");
endmodule // flag_branch_asserts
`default_nettype wire

//--- flag_conditional_branch_unit.sv
// Decode and execute of the two flag conditional relative branches
`timescale 1ns/10ps
`default_nettype none
`include "branch_defines.svh"
// How it works
// - Upper byte E5 branches only when overflow flag is clear.
// - Upper byte E1 branches only when zero flag is clear.
// - Taken: PC becomes incremented PC plus twice signed low byte.
// - One word; one cycle if not taken, two with flush cycle if taken.
module flag_conditional_branch_unit
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Instruction in
  input  wire logic              instr_valid,
  input  wire logic [15:0]       opcode,
  input  wire logic [4:0]        status_in,
  input  wire branch_pkg::pc_t   pc_in,
  // Results
  output var  logic              busy,
  output var  logic              pc_load,
  output var  branch_pkg::pc_t   pc_out,
  output var  logic              flush,
  output var  logic              done,
  output var  logic              taken,
  output var  logic [4:0]        status_out
);
  import branch_pkg::*;

  // Sequencer
  exec_state_t state_q;
  logic [1:0]  phase_q;
  // Operands captured at decode
  logic [15:0] opc_q;
  logic [4:0]  stat_q;
  pc_t         pcinc_q;
  // Decode and target
  logic        is_nov;
  logic        is_nz;
  logic        cond;
  pc_t         target;
  // Phase qualifiers
  logic        idle;
  logic        accept;
  logic        exec_data;
  logic        exec_last;
  logic        flush_run;
  logic        flush_last;
  logic        finish;

  // Words offered while busy are dropped, not queued
  assign idle       = state_q == ST_IDLE;
  assign accept     = idle && instr_valid;
  assign exec_data  = state_q == ST_EXEC && phase_q == `Q_DATA;
  assign exec_last  = state_q == ST_EXEC && phase_q == `Q_LAST;
  assign flush_run  = state_q == ST_FLUSH;
  assign flush_last = flush_run && phase_q == `Q_LAST;
  assign finish     = flush_last || (exec_last && !cond);

  // Tested on the flags latched at decode, not the live ones
  assign is_nov = opc_q[15:8] == `OPC_HI_NO_OVF;
  assign is_nz  = opc_q[15:8] == `OPC_HI_NONZERO;
  assign cond   = (is_nov & ~stat_q[`FLAG_OVF_BIT])
                | (is_nz  & ~stat_q[`FLAG_ZERO_BIT]);

  branch_target u_target
  (
    .pc_inc (pcinc_q),
    .offset (opc_q[7:0]),
    .target (target)
  );

  // Q phase counter, four phases per instruction cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      phase_q <= `Q_FIRST;
    else if (idle)
      phase_q <= `Q_FIRST;
    else
      phase_q <= phase_q + `Q_STEP;
  end

  // Sequencer; the flush cycle reuses the wrapped phase count,
  // so a taken branch costs exactly one extra instruction cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (instr_valid)
            state_q <= ST_EXEC;
        ST_EXEC:
          if (phase_q == `Q_LAST)
            state_q <= cond ? ST_FLUSH : ST_IDLE;
        ST_FLUSH:
          if (phase_q == `Q_LAST)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction word, held for the whole instruction
  always_ff @(posedge clk)
  begin
    if (!nrst)
      opc_q <= `OPCODE_RESET;
    else if (accept)
      opc_q <= opcode;
  end

  // Flags at decode; later changes on the input are ignored
  always_ff @(posedge clk)
  begin
    if (!nrst)
      stat_q <= `STATUS_RESET;
    else if (accept)
      stat_q <= status_in;
  end

  // Incremented PC, the base of both outcomes
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pcinc_q <= `PC_RESET;
    else if (accept)
      pcinc_q <= pc_in + `PC_STEP;
  end

  // PC load strobe in the cycle after the fourth phase
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pc_load <= 1'b0;
    else
      pc_load <= exec_last;
  end

  // New PC; the not-taken case still reports the sequential address
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pc_out <= `PC_RESET;
    else if (exec_last)
      pc_out <= cond ? target : pcinc_q;
  end

  // Outcome, held until the next instruction decides
  always_ff @(posedge clk)
  begin
    if (!nrst)
      taken <= 1'b0;
    else if (exec_last)
      taken <= cond;
  end

  // Prefetch discard spans the whole extra cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      flush <= 1'b0;
    else
      flush <= (exec_last && cond) || (flush_run && !flush_last);
  end

  // Busy drops with done, so a new word may follow at once
  always_ff @(posedge clk)
  begin
    if (!nrst)
      busy <= 1'b0;
    else if (idle)
      busy <= instr_valid;
    else
      busy <= !finish;
  end

  // End of instruction pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
      done <= 1'b0;
    else
      done <= finish;
  end

  // Flags pass through untouched
  always_ff @(posedge clk)
  begin
    if (!nrst)
      status_out <= `STATUS_RESET;
    else if (exec_data)
      status_out <= stat_q;
  end

endmodule // flag_conditional_branch_unit
`default_nettype wire

//--- tb_top.sv
// Bench for the branch unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import branch_pkg::*;
  logic        clk = 0, nrst = 0, instr_valid = 0, busy, pc_load, flush, done, taken, tk;
  logic [15:0] opcode = 0;
  logic [4:0]  status_in = 0, status_out, se;
  pc_t         pc_in = 0, pc_out, pe;
  int          n_errors = 0, samples_checked = 0, seed = 66645;
  always #5 clk = ~clk;
  flag_conditional_branch_unit i_flag_conditional_branch_unit (.clk, .nrst, .instr_valid,
    .opcode, .status_in, .pc_in, .busy, .pc_load, .pc_out, .flush, .done, .taken, .status_out);
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %0h got %0h", s, e, v);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] hi);
    opcode = {hi, 8'($random(seed))};
    status_in = 5'($random(seed));
    pc_in = pc_t'($random(seed));
    instr_valid = 1'b1;
    se = status_in;
    tk = hi == 8'hE5 ? !status_in[3] : hi == 8'hE1 ? !status_in[2] : 1'b0;
    // Signed int sum, so a negative offset is not zero extended
    pe = pc_t'(int'(pc_in) + 2 + (tk ? 2 * int'($signed(opcode[7:0])) : 0));
    @(posedge clk) #1;
    // Junk offered while busy must be ignored
    opcode = 16'($random(seed));
    status_in = 5'($random(seed));
    pc_in = pc_t'($random(seed));
    chk("busy", 32'(1), 32'(busy));
    repeat (4) @(posedge clk) #1;
    instr_valid = 1'b0;
    chk("pc_load", 32'(1), 32'(pc_load));
    chk("pc_out", 32'(pe), 32'(pc_out));
    chk("taken", 32'(tk), 32'(taken));
    chk("flush", 32'(tk), 32'(flush));
    chk("done", 32'(!tk), 32'(done));
    chk("status_out", 32'(se), 32'(status_out));
    if (tk) repeat (4) @(posedge clk) #1;
    chk("done", 32'(1), 32'(done));
    chk("busy", 32'(0), 32'(busy));
    chk("flush", 32'(0), 32'(flush));
    @(posedge clk) #1;
    chk("done", 32'(0), 32'(done));
    chk("pc_load", 32'(0), 32'(pc_load));
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    chk("reset outputs", 32'(0), 32'({busy, pc_load, flush, done, taken, pc_out, status_out}));
    for (int i = 0; i < 90; i++) run(i % 3 == 0 ? 8'hE5 : i % 3 == 1 ? 8'hE1 : 8'($random(seed)));
    report_and_stop;
  end
  initial
  begin
    #20000;
    n_errors++;
    report_and_stop;
  end
endmodule // tb_top
bind flag_conditional_branch_unit flag_branch_asserts i_flag_branch_asserts (.clk, .nrst,
  .instr_valid, .busy, .pc_load, .flush, .done, .taken, .opcode, .status_in, .status_out);
`default_nettype wire
